// *** tbc_mode_rate_ctrl.sv ***
// Control register A with AXI4-Lite access, mode selection and serial clock drive.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "tbc_map.svh"
module tbc_mode_rate_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        arbitration_lost,
  input  wire logic        receive_data_read,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_oe_allowed,
  output logic             reception_allowed,
  output tbc_pkg::tbc_mode_type mode,
  output logic             running
);
  import tbc_pkg::*;

  logic [7:0]  ctrl_a;
  logic [7:0]  next_ctrl_a;
  logic        aw_held;
  logic        next_aw_held;
  logic [11:0] aw_addr;
  logic [11:0] next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [7:0]  w_data;
  logic [7:0]  next_w_data;
  logic        w_strb0;
  logic        next_w_strb0;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        rx_blocked;
  logic        next_rx_blocked;
  logic        scl_low;
  logic        period_tick;
  logic        do_write;
  logic        is_master;

  ////////////////////////////////////////////////////////////////////////////////
  // Write and read channels: one transfer of each kind at a time.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb0 = w_strb0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata[7:0];
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr[11:2] == 10'(`TBC_CTRL_A_ADDR >> 2)) ? 2'h0 : 2'h2;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      if (s_axi_araddr[11:2] == 10'(`TBC_CTRL_A_ADDR >> 2)) begin
        next_rdata = {24'h00_0000, ctrl_a};
      end else if (s_axi_araddr[11:2] == 10'(`TBC_STATUS_ADDR >> 2)) begin
        next_rdata = {28'h000_0000, rx_blocked, scl_low, mode};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held      <= 1'b0;
      aw_addr      <= 12'h000;
      w_held       <= 1'b0;
      w_data       <= 8'h00;
      w_strb0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb0      <= next_w_strb0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register A and the reception gate.
  always_comb begin
    next_ctrl_a     = ctrl_a;
    next_rx_blocked = rx_blocked;
    if (do_write && w_strb0 && aw_addr[11:2] == 10'(`TBC_CTRL_A_ADDR >> 2)) begin
      next_ctrl_a = w_data;
    end
    // Hardware clear wins over a same-cycle software write, so a lost bus is never reclaimed by accident.
    if (arbitration_lost && ctrl_a[`TBC_MASTER_BIT]) begin
      next_ctrl_a[`TBC_MASTER_BIT]   = 1'b0;
      next_ctrl_a[`TBC_TRANSMIT_BIT] = 1'b0;
    end
    if (!ctrl_a[`TBC_ENABLE_BIT]) begin
      next_rx_blocked = 1'b0;
    end else if (receive_data_read && !ctrl_a[`TBC_TRANSMIT_BIT]) begin
      next_rx_blocked = ctrl_a[`TBC_RXDIS_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_a     <= `TBC_CTRL_A_RESET;
      rx_blocked <= 1'b0;
    end else begin
      ctrl_a     <= next_ctrl_a;
      rx_blocked <= next_rx_blocked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin drive.
  always_comb begin
    case (ctrl_a[`TBC_MASTER_BIT:`TBC_TRANSMIT_BIT])
      2'b00:   mode = TBC_SLAVE_RX;
      2'b01:   mode = TBC_SLAVE_TX;
      2'b10:   mode = TBC_MASTER_RX;
      default: mode = TBC_MASTER_TX;
    endcase
  end

  assign running           = ctrl_a[`TBC_ENABLE_BIT];
  assign is_master         = running && ctrl_a[`TBC_MASTER_BIT];
  assign reception_allowed = running && !rx_blocked;
  assign sda_oe_allowed    = running;
  assign scl_out           = 1'b0;
  // Only a master drives the clock, so the select bits cannot disturb slave timing.
  assign scl_oe            = is_master && scl_low;

  tbc_clk_div u_div (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .run          (is_master),
    .clock_select (ctrl_a[`TBC_CKS_HI:`TBC_CKS_LO]),
    .scl_in       (scl_in),
    .scl_low      (scl_low),
    .period_tick  (period_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_arb_clears_mode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    arbitration_lost && ctrl_a[`TBC_MASTER_BIT] |=> mode == TBC_SLAVE_RX)
    else $error("mode not slave receive after arbitration loss");
  chk_halt_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !running |-> !scl_oe && !sda_oe_allowed)
    else $error("pins driven while halted");
  chk_slave_no_clock: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ctrl_a[`TBC_MASTER_BIT] |=> !scl_oe)
    else $error("clock driven in slave mode");
  chk_rx_gate_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    running && receive_data_read && !ctrl_a[`TBC_TRANSMIT_BIT] && ctrl_a[`TBC_RXDIS_BIT] |=> !reception_allowed)
    else $error("reception not blocked");
  chk_rx_gate_open: assert property (@(posedge ref_clk) disable iff (!rst_b)
    running && receive_data_read && !ctrl_a[`TBC_TRANSMIT_BIT] && !ctrl_a[`TBC_RXDIS_BIT] |=> reception_allowed)
    else $error("reception not allowed");
  chk_period_28: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_master && period_tick && ctrl_a[3:0] == 4'h0 |=> !period_tick [*8])
    else $error("serial period too short");
  chk_double_rate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_master && ctrl_a[3:0] == 4'h8 && period_tick |=> scl_low [*8])
    else $error("low phase too short for divide by 56");
  chk_stretch_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_master && !scl_low && !scl_in && $stable(ctrl_a) |=> !period_tick)
    else $error("period ended while clock held low");
  chk_mode_decode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ctrl_a[5:4] == 2'b11 |-> mode == TBC_MASTER_TX)
    else $error("master transmit not decoded");
  chk_bresp_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cov_master_tx: cover property (@(posedge ref_clk) disable iff (!rst_b) mode == TBC_MASTER_TX && period_tick);
  cov_arb_loss: cover property (@(posedge ref_clk) disable iff (!rst_b) arbitration_lost && is_master);
  cov_rx_block: cover property (@(posedge ref_clk) disable iff (!rst_b) running && !reception_allowed);
  cov_stretch: cover property (@(posedge ref_clk) disable iff (!rst_b) is_master && !scl_low && !scl_in);
endmodule

// *** tbc_map.svh ***
// Register offsets, field positions, reset values and divisor counts of the bus control block.
// Summary of operation
// - Enable bit 0 halts the channel; 1 lets it run and drive the data pin, and the clock pin in master modes.
// - After a receive data read in a receive mode, reception_disable 0 allows, 1 blocks the next reception.
// - Master and transmit select bits pick slave/master receive/transmit mode.
// - Arbitration loss in master mode clears both select bits, giving slave receive.
// - Clock select bits affect bus timing only in master modes.
// - Top select bit 0: divide by 28,40,48,64,168,100,112,128.
// - Top select bit 1: divide by 56,80,96,128,336,200,224,256.
`ifndef TBC_MAP_SVH
`define TBC_MAP_SVH
`define TBC_CTRL_A_ADDR   12'h000
`define TBC_STATUS_ADDR   12'h004
`define TBC_CTRL_A_RESET  8'h00
`define TBC_ENABLE_BIT    7
`define TBC_RXDIS_BIT     6
`define TBC_MASTER_BIT    5
`define TBC_TRANSMIT_BIT  4
`define TBC_CKS_HI        3
`define TBC_CKS_LO        0
`define TBC_DIV_0 9'h01c
`define TBC_DIV_1 9'h028
`define TBC_DIV_2 9'h030
`define TBC_DIV_3 9'h040
`define TBC_DIV_4 9'h0a8
`define TBC_DIV_5 9'h064
`define TBC_DIV_6 9'h070
`define TBC_DIV_7 9'h080
`endif

// *** tbc_pkg.sv ***
// Types shared by the bus control block.
package tbc_pkg;
  typedef enum logic [1:0] {
    TBC_SLAVE_RX,
    TBC_SLAVE_TX,
    TBC_MASTER_RX,
    TBC_MASTER_TX
  } tbc_mode_type;
endpackage

// *** tbc_clk_div.sv ***
// Serial clock generator with low and high phases and clock stretching.
`timescale 1ns/100ps
`include "tbc_map.svh"
module tbc_clk_div (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [3:0] clock_select,
  input  wire logic       scl_in,
  output logic            scl_low,
  output logic            period_tick
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic       next_scl_low;
  logic [8:0] divisor;
  logic [8:0] half;

  always_comb begin
    case (clock_select[2:0])
      3'h0: divisor = `TBC_DIV_0;
      3'h1: divisor = `TBC_DIV_1;
      3'h2: divisor = `TBC_DIV_2;
      3'h3: divisor = `TBC_DIV_3;
      3'h4: divisor = `TBC_DIV_4;
      3'h5: divisor = `TBC_DIV_5;
      3'h6: divisor = `TBC_DIV_6;
      default: divisor = `TBC_DIV_7;
    endcase
    if (clock_select[3]) begin
      divisor = {divisor[7:0], 1'b0};
    end
    half = {1'b0, divisor[8:1]};
  end

  always_comb begin
    next_cnt     = cnt;
    next_scl_low = scl_low;
    period_tick  = 1'b0;
    if (!run) begin
      next_cnt     = 9'h000;
      next_scl_low = 1'b0;
    end else if (!scl_low && !scl_in) begin
      // High phase is held while another device pulls the clock low.
      next_cnt = cnt;
    end else if (cnt == divisor - 9'h001) begin
      next_cnt     = 9'h000;
      next_scl_low = 1'b1;
      period_tick  = 1'b1;
    end else begin
      next_cnt = cnt + 9'h001;
      if (cnt + 9'h001 == half) begin
        next_scl_low = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt     <= 9'h000;
      scl_low <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      scl_low <= next_scl_low;
    end
  end
endmodule

// *** tbc_bus_peer.sv ***
// Other device on the serial bus that can stretch the clock low.
`timescale 1ns/100ps
module tbc_bus_peer (
  input  wire logic       ref_clk,
  input  wire logic       scl_oe,
  input  wire logic [7:0] hold_cycles,
  output logic            scl_wire
);
  logic [7:0] cnt = 8'h00;
  logic       oe_q = 1'b0;
  // Sampled off the active edge so the peer never races the master.
  always @(negedge ref_clk) begin
    oe_q <= scl_oe;
    if (oe_q && !scl_oe) begin
      cnt <= hold_cycles;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // Pulled-up wire: low while either party pulls it.
  assign scl_wire = !(scl_oe || cnt != 8'h00);
endmodule

// *** tbc_mode_rate_ctrl_test.sv ***
// Self-checking bench for the mode and rate control block.
`timescale 1ns/100ps
`include "tbc_map.svh"
module tbc_mode_rate_ctrl_test;
  import tbc_pkg::*;
  logic         ref_clk = 1'b0, rst_b = 1'b0;
  logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]  wdata = 32'h0000_0000, rdata, rd;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, scl_wire, scl_out, scl_oe, sda_ok, rx_ok, running;
  logic [1:0]   bresp, rresp, rsp;
  logic         arb_lost = 1'b0, rx_read = 1'b0;
  logic [7:0]   hold = 8'h00;
  tbc_mode_type mode;
  int           n_mismatch = 0, n_tests = 0, per, lo;
  int           div_base [8] = '{28, 40, 48, 64, 168, 100, 112, 128};

  always #10 ref_clk = ~ref_clk;

  tbc_mode_rate_ctrl tbc_mode_rate_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .arbitration_lost(arb_lost), .receive_data_read(rx_read), .scl_in(scl_wire), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_oe_allowed(sda_ok), .reception_allowed(rx_ok), .mode(mode), .running(running));
  tbc_bus_peer tbc_bus_peer_i (.ref_clk(ref_clk), .scl_oe(scl_oe), .hold_cycles(hold), .scl_wire(scl_wire));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Handshakes are judged at the falling edge, where every level is settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (tb !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
    end while (tr !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic setc(input logic [7:0] v);
    wr(`TBC_CTRL_A_ADDR, {24'h00_0000, v}, rsp);
    check("write response", 32'h0, {30'h0, rsp});
  endtask

  // The first pass aligns to a low phase start, the second measures one period.
  task automatic measure();
    logic last;
    for (int k = 0; k < 2; k++) begin
      per  = 0;
      lo   = 0;
      last = scl_oe;
      do begin
        last = scl_oe;
        @(negedge ref_clk);
        per++;
        lo += (scl_oe === 1'b1);
      end while (!(scl_oe === 1'b1 && last === 1'b0) && per < 1200);
    end
    lo--;
  endtask

  task automatic t_reset_modes();
    rd_reg(`TBC_CTRL_A_ADDR, rd, rsp);
    check("control reset", 32'h0, rd);
    for (int m = 0; m < 4; m++) begin
      setc({2'b00, m[1:0], 4'h0});
      check("mode", m, {30'h0, mode});
      check("idle drive", 32'h0, {28'h0, running, scl_oe, sda_ok, rx_ok});
      rd_reg(`TBC_STATUS_ADDR, rd, rsp);
      check("status mode", m, rd & 32'h3);
    end
  endtask

  task automatic t_rates();
    for (int c = 0; c < 16; c++) begin
      setc(8'hA0 | c[7:0]);
      measure();
      check("period", div_base[c % 8] << (c / 8), per);
      check("low half", 1, lo >= div_base[c % 8] * (1 << (c / 8)) / 2 - 1 && lo <= per / 2 + 1);
    end
    check("running", 32'h3, {30'h0, running, sda_ok});
  endtask

  task automatic t_quiet();
    int hi;
    for (int s = 0; s < 3; s++) begin
      setc(s == 2 ? 8'h20 : (s == 0 ? 8'h83 : 8'h9b));
      hi = 0;
      repeat (700) begin
        @(negedge ref_clk);
        hi += (scl_oe === 1'b1);
      end
      check("clock drive", 0, hi);
      check("clock level", 0, scl_out);
    end
  endtask

  task automatic t_stretch();
    setc(8'hA0);
    hold <= 8'd10;
    measure();
    check("stretched", 1, per >= 38);
    hold <= 8'd0;
  endtask

  task automatic t_arb();
    setc(8'hB5);
    @(posedge ref_clk);
    arb_lost <= 1'b1;
    @(posedge ref_clk);
    arb_lost <= 1'b0;
    rd_reg(`TBC_CTRL_A_ADDR, rd, rsp);
    check("after arbitration", 32'h85, rd);
    check("mode slave rx", TBC_SLAVE_RX, {30'h0, mode});
  endtask

  task automatic pulse_read(input logic exp);
    @(posedge ref_clk);
    rx_read <= 1'b1;
    @(posedge ref_clk);
    rx_read <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("reception allowed", exp, rx_ok);
  endtask

  task automatic t_rx();
    setc(8'hD0);
    pulse_read(1'b1);
    setc(8'hC0);
    pulse_read(1'b0);
    rd_reg(`TBC_STATUS_ADDR, rd, rsp);
    check("status blocked", 32'h8, rd & 32'h8);
    setc(8'h80);
    check("still blocked", 0, rx_ok);
    pulse_read(1'b1);
  endtask

  task automatic t_unmapped();
    rd_reg(12'h008, rd, rsp);
    check("unmapped read", 32'h2, {rd[29:0], rsp});
    wr(12'h008, 32'h0000_0055, rsp);
    check("unmapped write", 32'h2, {30'h0, rsp});
    rd_reg(`TBC_CTRL_A_ADDR, rd, rsp);
    check("kept value", 32'h80, rd);
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset_modes();
    t_rates();
    t_quiet();
    t_stretch();
    t_arb();
    t_rx();
    t_unmapped();
    conclude();
  end

  // Whole run is well under 10000 cycles; this limit leaves a wide margin.
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
endmodule
